/* hw/irs_sensor.sv */
// IR array sensor die: two-wire command decoder, trim and configuration
// registers, and the conversion scanner that fills the result RAM.
// Assumes meas_data is the front end's raw reading for meas_idx on clk.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Trim write uses 0xAA check bytes
// - Configuration write uses 0x55 check bytes
// - Reset clears the configuration reset flag
// - Default: 1 Hz, awake, fast mode, low reference
// - Scan all pixels and die sensor repeatedly
// - Configuration read at 0x92, one word
// - Row read steps addresses by step value
// - Single pixel read returns one word
// - Frame, row, pixel, compensation pixel reads
// - Words go out low byte first
// - Die result doubles per resolution step
module irs_sensor
   import irs_pkg::*;
#(
   parameter int SLOT_CYC = int'(FRAME_1HZ_CYC / NCONV),
   parameter int DW = 16
)(
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic [DW-1:0] meas_data,
   output logic [6:0] meas_idx,
   output logic [15:0] osc_trim,
   output logic sleep_mode,
   output logic fmp_en,
   output logic adc_low_ref
);
   irs_link_if lnk();

   logic scl_s1, scl_s2, scl_s3;
   logic sda_s1, sda_s2, sda_s3;
   logic tgl_s1, tgl_s2, tgl_s3;
   logic frame_rst_n_reg;
   irs_state_t state_reg, state_next;
   logic [7:0] cmd_reg, cmd_next;
   logic [1:0] pidx_reg, pidx_next;
   logic [7:0] p0_reg, p0_next, p1_reg, p1_next, p2_reg, p2_next;
   logic [7:0] addr_reg, addr_next, step_reg, step_next, left_reg, left_next;
   logic hi_reg, hi_next;
   logic [7:0] tx_reg, tx_next;
   logic [15:0] cfg_reg, cfg_next, trim_reg, trim_next;
   logic [15:0] ram [0:NCONV-1];
   logic [6:0] idx_reg;
   logic [31:0] slot_cnt_reg;

   wire logic start_cond, stop_cond, rx_ev, addr_ev, par_ev, last_par;
   wire logic known_cmd, trim_ok, cfg_ok, trim_wr, cfg_wr, rd_setup;
   wire logic [7:0] rx;
   wire logic [15:0] cur_word, nxt_word, store_val;
   wire logic [3:0] rate;
   wire logic [1:0] res;
   wire logic [31:0] slot_base, slot_len;
   wire logic slot_tick, conv;

   function automatic logic [15:0] word_at(input logic [7:0] a);
      logic [15:0] w;
      w = '0;
      if (a <= A_CPIX) begin
         w = ram[a[6:0]];
      end else if (a == A_CFG) begin
         w = cfg_reg;
      end else if (a == A_TRIM) begin
         w = trim_reg;
      end
      return w;
   endfunction

   irs_link u_link (
      .scl(scl),
      .nrst(nrst),
      .sda_in(sda_in),
      .sda_oe_n(sda_oe_n),
      .lnk(lnk.link)
   );

   assign lnk.tx_byte = tx_reg;
   assign lnk.frame_rst_n = frame_rst_n_reg;
   assign sda_out = 1'b0;

   // Pin synchronisers; the second and third stages feed edge detection
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         {scl_s1, scl_s2, scl_s3} <= 3'h7;
         {sda_s1, sda_s2, sda_s3} <= 3'h7;
         {tgl_s1, tgl_s2, tgl_s3} <= 3'h0;
      end else begin
         {scl_s1, scl_s2, scl_s3} <= {scl, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
         {tgl_s1, tgl_s2, tgl_s3} <= {lnk.rx_tgl, tgl_s1, tgl_s2};
      end
   end

   assign start_cond = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
   assign stop_cond = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
   assign rx_ev = (tgl_s2 ^ tgl_s3) && !stop_cond;
   assign rx = lnk.rx_byte;
   assign addr_ev = rx_ev && lnk.addr_byte;
   assign par_ev = rx_ev && !lnk.addr_byte && (state_reg == ST_PAR);
   assign last_par = (pidx_reg == PAR_WR_LAST);
   assign known_cmd = (rx == CMD_RAM_RD) || (rx == CMD_CFG_WR) || (rx == CMD_TRIM_WR);
   assign trim_ok = (cmd_reg == CMD_TRIM_WR) && (p0_reg == p1_reg - CHK_TRIM) && (p2_reg == rx - CHK_TRIM);
   assign cfg_ok = (cmd_reg == CMD_CFG_WR) && (p0_reg == p1_reg - CHK_CFG) && (p2_reg == rx - CHK_CFG);
   assign trim_wr = par_ev && last_par && trim_ok;
   assign cfg_wr = par_ev && last_par && cfg_ok;
   assign rd_setup = par_ev && (cmd_reg == CMD_RAM_RD) && (pidx_reg == PAR_RD_LAST);
   assign cur_word = word_at(addr_reg);
   assign nxt_word = word_at(addr_reg + step_reg);

   // Frame reset for the link logic on start and stop
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         frame_rst_n_reg <= 1'b1;
      end else begin
         frame_rst_n_reg <= !(start_cond || stop_cond);
      end
   end

   always_comb begin
      state_next = state_reg;
      cmd_next = cmd_reg;
      pidx_next = pidx_reg;
      p0_next = p0_reg;
      p1_next = p1_reg;
      p2_next = p2_reg;
      addr_next = addr_reg;
      step_next = step_reg;
      left_next = left_reg;
      hi_next = hi_reg;
      tx_next = tx_reg;
      cfg_next = cfg_wr ? {rx, p1_reg} : cfg_reg;
      trim_next = trim_wr ? {rx, p1_reg} : trim_reg;
      if (stop_cond) begin
         state_next = ST_IDLE;
      end else if (addr_ev) begin
         if (!lnk.sel) begin
            state_next = ST_SKIP;
         end else if (lnk.rd) begin
            state_next = ST_RD;
            hi_next = 1'b0;
            tx_next = (left_reg == '0) ? IDLE_BYTE : cur_word[7:0];
         end else begin
            state_next = ST_CMD;
         end
      end else if (rx_ev) begin
         case (state_reg)
            ST_CMD: begin
               cmd_next = rx;
               pidx_next = '0;
               state_next = known_cmd ? ST_PAR : ST_SKIP;
            end
            ST_PAR: begin
               pidx_next = pidx_reg + 2'h1;
               case (pidx_reg)
                  2'h0: p0_next = rx;
                  2'h1: p1_next = rx;
                  2'h2: p2_next = rx;
                  default: ;
               endcase
               if (rd_setup) begin
                  addr_next = p0_reg;
                  step_next = p1_reg;
                  left_next = rx;
                  state_next = ST_IDLE;
               end else if (last_par) begin
                  state_next = ST_SKIP;
               end
            end
            ST_RD: begin
               if (left_reg == '0) begin
                  tx_next = IDLE_BYTE;
               end else if (!hi_reg) begin
                  hi_next = 1'b1;
                  tx_next = cur_word[15:8];
               end else begin
                  hi_next = 1'b0;
                  left_next = left_reg - 8'h1;
                  addr_next = addr_reg + step_reg;
                  tx_next = (left_reg > 8'h1) ? nxt_word[7:0] : IDLE_BYTE;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         cmd_reg <= '0;
         pidx_reg <= '0;
         {p0_reg, p1_reg, p2_reg} <= '0;
         {addr_reg, step_reg, left_reg} <= '0;
         hi_reg <= 1'b0;
         tx_reg <= IDLE_BYTE;
         cfg_reg <= CFG_RST;
         trim_reg <= TRIM_RST;
      end else begin
         state_reg <= state_next;
         cmd_reg <= cmd_next;
         pidx_reg <= pidx_next;
         {p0_reg, p1_reg, p2_reg} <= {p0_next, p1_next, p2_next};
         {addr_reg, step_reg, left_reg} <= {addr_next, step_next, left_next};
         hi_reg <= hi_next;
         tx_reg <= tx_next;
         cfg_reg <= cfg_next;
         trim_reg <= trim_next;
      end
   end

   assign rate = cfg_reg[CFG_RATE_LO +: 4];
   assign res = cfg_reg[CFG_RES_LO +: 2];
   assign sleep_mode = cfg_reg[CFG_SLEEP];
   assign fmp_en = !cfg_reg[CFG_FMP_DIS];
   assign adc_low_ref = cfg_reg[CFG_LREF];
   assign osc_trim = trim_reg;
   assign meas_idx = idx_reg;

   assign slot_base = 32'(SLOT_CYC);
   assign slot_len = (rate >= RATE_1HZ) ? (slot_base << (rate - RATE_1HZ)) : (slot_base >> (RATE_1HZ - rate));
   assign slot_tick = (slot_len == '0) || (slot_cnt_reg >= slot_len - 32'h1);
   assign conv = slot_tick && !sleep_mode;
   assign store_val = 16'(meas_data >> (RES_FULL - res));

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         slot_cnt_reg <= '0;
         idx_reg <= '0;
      end else begin
         slot_cnt_reg <= (sleep_mode || slot_tick) ? '0 : slot_cnt_reg + 32'h1;
         if (conv) begin
            idx_reg <= (idx_reg == CONV_LAST) ? '0 : idx_reg + 7'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (conv) begin
         ram[idx_reg] <= store_val;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   property p_trim_wr;
      trim_wr |=> (trim_reg == $past({rx, p1_reg})) && (osc_trim == trim_reg);
   endproperty
   a_trim_wr: assert property (p_trim_wr) else $error("trim not written");
   property p_cfg_wr;
      cfg_wr |=> cfg_reg == $past({rx, p1_reg});
   endproperty
   a_cfg_wr: assert property (p_cfg_wr) else $error("configuration not written");
   property p_bad_check;
      (par_ev && last_par && !trim_ok && !cfg_ok) |=> $stable(trim_reg) && $stable(cfg_reg);
   endproperty
   a_bad_check: assert property (p_bad_check) else $error("bad check bytes changed a register");
   property p_por_flag;
      $rose(cfg_reg[CFG_POR]) |-> $past(cfg_wr);
   endproperty
   a_por_flag: assert property (p_por_flag) else $error("reset flag set without a write");
   property p_scan_step;
      (conv && idx_reg != CONV_LAST) |=> idx_reg == $past(idx_reg) + 7'h1;
   endproperty
   a_scan_step: assert property (p_scan_step) else $error("scan index did not advance");
   property p_full_res;
      (conv && res == RES_FULL) |=> ram[$past(idx_reg)] == $past(meas_data[15:0]);
   endproperty
   a_full_res: assert property (p_full_res) else $error("full resolution result altered");
   property p_hi_byte;
      (rx_ev && state_reg == ST_RD && !lnk.addr_byte && !hi_reg && left_reg != '0)
         |=> tx_reg == $past(cur_word[15:8]);
   endproperty
   a_hi_byte: assert property (p_hi_byte) else $error("high byte not sent after low byte");
   property p_rd_step;
      (rx_ev && state_reg == ST_RD && !lnk.addr_byte && hi_reg && left_reg != '0)
         |=> (addr_reg == $past(addr_reg + step_reg)) && (left_reg == $past(left_reg) - 8'h1);
   endproperty
   a_rd_step: assert property (p_rd_step) else $error("read address did not step");
   property p_rd_end;
      (rx_ev && state_reg == ST_RD && !lnk.addr_byte && hi_reg && left_reg == 8'h1)
         |=> tx_reg == IDLE_BYTE ##1 left_reg == '0;
   endproperty
   a_rd_end: assert property (p_rd_end) else $error("read ran past its count");
   property p_rd_setup;
      rd_setup |=> (left_reg == $past(rx)) && (addr_reg == $past(p0_reg)) && (state_reg == ST_IDLE);
   endproperty
   a_rd_setup: assert property (p_rd_setup) else $error("read parameters not taken");

   c_trim: cover property (trim_wr);
   c_read: cover property (addr_ev && lnk.rd && lnk.sel);
   c_wrap: cover property (conv && idx_reg == CONV_LAST);
endmodule // irs_sensor
`default_nettype wire

/* hw/irs_pkg.sv */
// Constants, field layout and state codes for the IR array sensor die.
// Assumes a 50 MHz core clock and a two-wire link clocked by the bus master.
package irs_pkg;
   localparam logic [6:0] DEV_ADDR = 7'h60;
   localparam logic [7:0] CMD_RAM_RD = 8'h02;
   localparam logic [7:0] CMD_CFG_WR = 8'h03;
   localparam logic [7:0] CMD_TRIM_WR = 8'h04;
   localparam logic [7:0] CHK_TRIM = 8'hAA;
   localparam logic [7:0] CHK_CFG = 8'h55;
   localparam logic [7:0] A_DIE = 8'h40;
   localparam logic [7:0] A_CPIX = 8'h41;
   localparam logic [7:0] A_CFG = 8'h92;
   localparam logic [7:0] A_TRIM = 8'h93;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   localparam logic [15:0] CFG_RST = 16'h423E;
   localparam logic [15:0] TRIM_RST = 16'h0000;
   localparam int CFG_RATE_LO = 0;
   localparam int CFG_RES_LO = 4;
   localparam int CFG_SLEEP = 6;
   localparam int CFG_POR = 10;
   localparam int CFG_FMP_DIS = 11;
   localparam int CFG_LREF = 14;
   localparam logic [3:0] RATE_1HZ = 4'hE;
   localparam logic [1:0] RES_FULL = 2'h3;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [1:0] PAR_RD_LAST = 2'h2;
   localparam logic [1:0] PAR_WR_LAST = 2'h3;
   localparam int NCONV = 66;
   localparam logic [6:0] CONV_LAST = 7'h41;
   localparam longint FRAME_1HZ_NS = 1000000000;
   localparam longint CLK_PERIOD_NS = 20;
   localparam longint FRAME_1HZ_CYC = FRAME_1HZ_NS / CLK_PERIOD_NS;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CMD = 3'b001,
      ST_PAR = 3'b010,
      ST_RD = 3'b011,
      ST_SKIP = 3'b100
   } irs_state_t;
endpackage

/* hw/irs_link_if.sv */
// Signals between the link-clock byte engine and the core-clock command logic.
// Words passed here change with their toggle and stay stable for a whole byte time after it.
`timescale 1ns/1ps
`default_nettype none
interface irs_link_if;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;
   logic rx_tgl;
   logic addr_byte;
   logic rd;
   logic sel;
   logic frame_rst_n;
   modport link(output rx_byte, rx_tgl, addr_byte, rd, sel, input tx_byte, frame_rst_n);
   modport core(input rx_byte, rx_tgl, addr_byte, rd, sel, output tx_byte, frame_rst_n);
endinterface
`default_nettype wire

/* hw/irs_link.sv */
// Two-wire byte engine clocked by the bus clock pin.
// Assumes start and stop are seen by the core, which resets this logic per frame.
`timescale 1ns/1ps
`default_nettype none
module irs_link
   import irs_pkg::*;
(
   input wire logic scl,
   input wire logic nrst,
   input wire logic sda_in,
   output logic sda_oe_n,
   irs_link_if.link lnk
);
   logic [3:0] cnt_reg;
   logic [6:0] sr_reg;
   logic first_reg;
   logic tgl_reg;
   logic arst_n;
   logic byte_end;
   logic ack_slot;
   logic drive_ack;

   // Frame reset comes from the core on every start or stop
   assign arst_n = nrst & lnk.frame_rst_n;
   assign byte_end = (cnt_reg == BIT_LAST);
   assign ack_slot = (cnt_reg == ACK_SLOT);
   assign drive_ack = lnk.sel && (lnk.addr_byte || !lnk.rd);
   assign lnk.rx_tgl = tgl_reg;

   always_ff @(posedge scl or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= '0;
         sr_reg <= '0;
         first_reg <= 1'b1;
         lnk.addr_byte <= 1'b0;
         lnk.sel <= 1'b0;
         lnk.rd <= 1'b0;
      end else if (ack_slot) begin
         cnt_reg <= '0;
         // Master nack ends a read
         if (!lnk.addr_byte && lnk.rd && sda_in) begin
            lnk.sel <= 1'b0;
         end
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
         sr_reg <= {sr_reg[5:0], sda_in};
         if (byte_end) begin
            first_reg <= 1'b0;
            lnk.addr_byte <= first_reg;
            if (first_reg) begin
               lnk.sel <= (sr_reg == DEV_ADDR);
               lnk.rd <= sda_in;
            end
         end
      end
   end

   // Byte data and its toggle survive the frame reset
   always_ff @(posedge scl or negedge nrst) begin
      if (!nrst) begin
         tgl_reg <= 1'b0;
         lnk.rx_byte <= '0;
      end else if (byte_end) begin
         tgl_reg <= ~tgl_reg;
         lnk.rx_byte <= {sr_reg, sda_in};
      end
   end

   always_ff @(negedge scl or negedge arst_n) begin
      if (!arst_n) begin
         sda_oe_n <= 1'b1;
      end else if (ack_slot) begin
         sda_oe_n <= !drive_ack;
      end else if (lnk.rd && lnk.sel) begin
         sda_oe_n <= lnk.tx_byte[3'h7 - cnt_reg[2:0]];
      end else begin
         sda_oe_n <= 1'b1;
      end
   end

   property p_ack_low;
      @(negedge scl) disable iff (!nrst)
      (ack_slot && lnk.sel && lnk.addr_byte && lnk.frame_rst_n) |=> !sda_oe_n;
   endproperty
   a_ack_low: assert property (p_ack_low) else $error("address not acknowledged");
endmodule // irs_link
`default_nettype wire

/* tb/irs_host_model.sv */
// Two-wire bus master standing in for the host controller.
// Assumes a pull-up on SDA resolved by the bench; SCL idles high between frames.
`timescale 1ns/1ps
`default_nettype none
module irs_host_model (
   output logic scl,
   output logic sda_oe_n,
   input wire logic sda
);
   localparam realtime HALF = 62.5;
   localparam realtime HOLD = 200.0;
   initial begin
      scl = 1'h1;
      sda_oe_n = 1'h1;
   end
   task automatic start_cond();
      if (scl === 1'h0) begin
         #(HALF / 2) sda_oe_n = 1'h1;
         #(HALF / 2) scl = 1'h1;
      end
      #(HOLD) sda_oe_n = 1'h0;
      #(HOLD) scl = 1'h0;
   endtask
   task automatic stop_cond();
      #(HALF / 2) sda_oe_n = 1'h0;
      #(HALF / 2) scl = 1'h1;
      #(HOLD) sda_oe_n = 1'h1;
      #(HOLD);
   endtask
   // Data changes only while SCL is low, sampled at the rising edge
   task automatic clk_bit(input logic b, output logic s);
      #(HALF / 2) sda_oe_n = b;
      #(HALF / 2) scl = 1'h1;
      s = sda;
      #(HALF) scl = 1'h0;
   endtask
   // bytes sent most significant bit first
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
      clk_bit(1'h1, ack);
   endtask
   // master acks all but the last byte
   task automatic rbyte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(1'h1, b[i]);
      clk_bit(last, s);
   endtask
endmodule // irs_host_model
`default_nettype wire

/* tb/test_irs_sensor.sv */
// Bench for the IR array sensor die: frames built from host model calls.
// Assumes front-end readings are a fixed pattern of the conversion index.
`timescale 1ns/1ps
`default_nettype none
module test_irs_sensor
   import irs_pkg::*;
;
   localparam int SLOT = 8;
   localparam realtime INIT_WAIT_NS = 5000.0;
   // Sample calibration shift byte: linear shift in [7:4], quadratic in [3:0]
   localparam logic [7:0] AMB_SHIFTS = 8'h8B;
   logic clk = 1'h0;
   // Starts high so that the first reset is a real falling edge
   logic nrst = 1'h1;
   logic scl, host_oe_n, sda_out, dut_oe_n, sleep_mode, fmp_en, adc_low_ref, ack;
   logic [6:0] meas_idx;
   logic [15:0] osc_trim, cfg_exp, trim_exp;
   int miscompares = 0;
   int total_checks = 0;
   wire sda = (dut_oe_n | sda_out) & host_oe_n;
   wire [15:0] meas_data = {1'h1, meas_idx, 8'h5A};

   always #10 clk = ~clk;

   irs_sensor #(.SLOT_CYC(SLOT), .DW(16)) DUT (
      .clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(dut_oe_n),
      .meas_data(meas_data), .meas_idx(meas_idx), .osc_trim(osc_trim), .sleep_mode(sleep_mode),
      .fmp_en(fmp_en), .adc_low_ref(adc_low_ref));
   irs_host_model host (.scl(scl), .sda_oe_n(host_oe_n), .sda(sda));

   function automatic logic [15:0] exp_at(input logic [7:0] a);
      if (a <= A_CPIX) return {1'h1, a[6:0], 8'h5A} >> (2'h3 - cfg_exp[CFG_RES_LO +: 2]);
      else if (a == A_CFG) return cfg_exp;
      else if (a == A_TRIM) return trim_exp;
      return 16'h0000;
   endfunction

   task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic pins_chk();
      chk("osc_trim", trim_exp, osc_trim);
      chk("modes", {13'h0000, cfg_exp[CFG_SLEEP], ~cfg_exp[CFG_FMP_DIS], cfg_exp[CFG_LREF]},
         {13'h0000, sleep_mode, fmp_en, adc_low_ref});
   endtask

   // host decoding of one ambient constant
   function automatic int amb_decode(input logic [7:0] lo, input logic [7:0] hi, input int sh, input logic [1:0] r);
      int v;
      v = 256 * int'(hi) + int'(lo);
      if (v > 32767) v = v - 65536;
      return v >>> (sh + 3 - int'(r));
   endfunction

   // Check bytes are data minus offset; a bad frame spoils the low check byte
   task automatic wr_word(input logic [7:0] cmd, input logic [7:0] ck, input logic [15:0] v, input logic good);
      logic [7:0] b [6];
      logic a;
      b = '{8'hC0, cmd, v[7:0] - ck + {7'h00, ~good}, v[7:0], v[15:8] - ck, v[15:8]};
      host.start_cond();
      foreach (b[i]) begin
         host.wbyte(b[i], a);
         chk("write ack", 16'h0000, {15'h0000, a});
      end
      host.stop_cond();
      if (good && cmd == CMD_TRIM_WR) trim_exp = v;
      if (good && cmd == CMD_CFG_WR) cfg_exp = v;
      repeat (4) @(posedge clk);
      #1;
      pins_chk();
   endtask

   // Parameterised read; extra reads one byte past the count
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] st, input logic [7:0] n, input logic extra);
      logic [7:0] p [5];
      logic [7:0] lo, hi;
      logic k;
      p = '{8'hC0, CMD_RAM_RD, a, st, n};
      host.start_cond();
      foreach (p[i]) begin
         host.wbyte(p[i], k);
         chk("param ack", 16'h0000, {15'h0000, k});
      end
      host.start_cond();
      host.wbyte(8'hC1, k);
      chk("read ack", 16'h0000, {15'h0000, k});
      for (int i = 0; i < n; i++) begin
         host.rbyte(1'h0, lo);
         host.rbyte(!extra && i == n - 1, hi);
         chk("word", exp_at(a + 8'(i) * st), {hi, lo});
      end
      if (extra) begin
         host.rbyte(1'h1, lo);
         chk("past count", 16'h00FF, {8'h00, lo});
      end
      host.stop_cond();
   endtask

   task automatic do_reset();
      @(posedge clk);
      #1 nrst = 1'h0;
      cfg_exp = CFG_RST;
      trim_exp = TRIM_RST;
      repeat (4) @(posedge clk);
      #1 nrst = 1'h1;
      // scaled wait before the first frame
      #(INIT_WAIT_NS);
   endtask

   task automatic give_verdict();
      if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      #1000000;
      miscompares++;
      give_verdict();
   end

   initial begin
      do_reset();
      pins_chk();
      chk("ambient_offset_constant", 16'h0C84, 16'(amb_decode(8'h20, 8'h64, 0, 2'h0)));
      chk("ambient_linear_coefficient", 16'h0055, 16'(amb_decode(8'h89, 8'h55, AMB_SHIFTS[7:4], 2'h3)));
      chk("ambient_quadratic_coefficient", 16'hFFFF,
         16'(amb_decode(8'h00, 8'h80, AMB_SHIFTS[3:0] + 10, 2'h3)));
      host.start_cond();
      host.wbyte(8'hA0, ack);
      host.stop_cond();
      chk("other target ack", 16'h0001, {15'h0000, ack});
      rd_chk(A_CFG, 8'h00, 8'h01, 1'h1);
      wr_word(CMD_TRIM_WR, CHK_TRIM, 16'h0052, 1'h1);
      wr_word(CMD_TRIM_WR, CHK_TRIM, 16'h1234, 1'h0);
      rd_chk(A_TRIM, 8'h00, 8'h01, 1'h0);
      wr_word(CMD_CFG_WR, CHK_CFG, 16'h463E, 1'h1);
      wr_word(CMD_CFG_WR, CHK_CFG, 16'h0C7E, 1'h0);
      rd_chk(A_CFG, 8'h00, 8'h01, 1'h0);
      repeat (1200) @(posedge clk);
      rd_chk(8'h01, 8'h04, 8'h10, 1'h0);
      rd_chk(8'h3F, 8'h00, 8'h01, 1'h1);
      rd_chk(8'h00, 8'h01, 8'h40, 1'h0);
      rd_chk(A_DIE, 8'h00, 8'h01, 1'h0);
      rd_chk(A_CPIX, 8'h00, 8'h01, 1'h0);
      for (int r = 0; r < 3; r++) begin
         wr_word(CMD_CFG_WR, CHK_CFG, 16'h460E | 16'(r << CFG_RES_LO), 1'h1);
         repeat (1200) @(posedge clk);
         rd_chk(A_DIE, 8'h00, 8'h01, 1'h0);
      end
      wr_word(CMD_CFG_WR, CHK_CFG, 16'h0C7E, 1'h1);
      wr_word(CMD_CFG_WR, CHK_CFG, 16'h463E, 1'h1);
      do_reset();
      pins_chk();
      rd_chk(A_CFG, 8'h00, 8'h01, 1'h0);
      give_verdict();
   end
endmodule // test_irs_sensor
`default_nettype wire
